// ### logic/wpq_pkg.sv
// wpq_pkg: constants for the watchpoint qualifier and debug management window
// assumes a 12-bit byte offset on the coprocessor register port, 32-bit data
// Functional notes
// - access field b01 load, b10 store, b11 either
// - swaps hit on any nonzero access encoding
// - load exclusive hits on load or either
// - store exclusive hits only when monitor passes
// - store exclusive may fault regardless of monitor
// - privilege field b01 priv, b10 user, b11 all
// - privilege taken from the access, not mode
// - bit 0 enables watchpoint, reset value zero
// - management registers reached over coprocessor port
// - standard management registers at fixed offsets
// - reserved expansion range reads as zero
// - security field b00 both, b01 ns, b10 s
// - linked watchpoint needs address and context hit
package wpq_pkg;
	// ==========================================================
	// sizes
	localparam int WP_NUM = 4;
	localparam int OWN_W = 8;
	// ==========================================================
	// register offsets
	localparam logic [11:0] OFF_WC_BASE = 12'h1C0;
	localparam logic [11:0] OFF_ITC = 12'hF00;
	localparam logic [11:0] OFF_RSV_LO = 12'hF04;
	localparam logic [11:0] OFF_RSV_HI = 12'hF9C;
	localparam logic [11:0] OFF_OWN_SET = 12'hFA0;
	localparam logic [11:0] OFF_OWN_CLR = 12'hFA4;
	localparam logic [11:0] OFF_UNLOCK_KEY = 12'hFB0;
	localparam logic [11:0] OFF_UNLOCK_STATE = 12'hFB4;
	localparam logic [11:0] OFF_PERMIT = 12'hFB8;
	localparam logic [11:0] OFF_COMP_ID = 12'hFC8;
	localparam logic [11:0] OFF_COMP_CLASS = 12'hFCC;
	// ==========================================================
	// watch control fields
	localparam int WC_EN_BIT = 0;
	localparam int WC_PRIV_LSB = 1;
	localparam int WC_LS_LSB = 3;
	localparam int WC_SEC_LSB = 14;
	localparam int WC_LINK_BIT = 20;
	localparam logic [31:0] WC_WMASK = 32'h1F1F_C1FF;
	localparam logic [31:0] WC_RESET = 32'h0000_0000;
	// ==========================================================
	// field encodings
	localparam logic [1:0] LS_LOAD = 2'b01;
	localparam logic [1:0] LS_STORE = 2'b10;
	localparam logic [1:0] LS_EITHER = 2'b11;
	localparam logic [1:0] PRIV_ONLY = 2'b01;
	localparam logic [1:0] PRIV_USER = 2'b10;
	localparam logic [1:0] PRIV_ANY = 2'b11;
	localparam logic [1:0] SEC_BOTH = 2'b00;
	localparam logic [1:0] SEC_NS = 2'b01;
	localparam logic [1:0] SEC_S = 2'b10;
	localparam logic [1:0] PERMIT_ON = 2'b11;
	localparam logic [1:0] PERMIT_OFF = 2'b10;
	// ==========================================================
	// management fields and reset values
	localparam int ITC_BIT = 0;
	localparam logic ITC_RESET = 1'b0;
	localparam int LOCK_IMPL_BIT = 0;
	localparam int LOCK_SET_BIT = 1;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic [7:0] OWN_RESET = 8'h00;
	// arbitrary values, not tied to any real part
	localparam logic [31:0] UNLOCK_KEY_DEF = 32'h5A5A_0001;
	localparam logic [31:0] COMP_ID_DEF = 32'h0000_0000;
	localparam logic [31:0] COMP_CLASS_DEF = 32'h0000_0001;
endpackage

// ### logic/wpq_qual.sv
// wpq_qual: combinational qualifier for one watchpoint
// assumes address/mask compare and context compare are done upstream
`timescale 1ns/10ps
module wpq_qual (
	input wire logic [31:0] ctrl_in,
	input wire logic acc_load_in,
	input wire logic acc_store_in,
	input wire logic acc_excl_in,
	input wire logic excl_pass_in,
	input wire logic acc_priv_in,
	input wire logic acc_secure_in,
	input wire logic addr_hit_in,
	input wire logic ctx_hit_in,
	output logic match_out
);
	logic [1:0] ls;
	logic [1:0] priv;
	logic [1:0] sec;
	logic type_ok;
	logic priv_ok;
	logic sec_ok;
	logic link_ok;

	// ==========================================================
	// field split
	assign ls = ctrl_in[wpq_pkg::WC_LS_LSB +: 2];
	assign priv = ctrl_in[wpq_pkg::WC_PRIV_LSB +: 2];
	assign sec = ctrl_in[wpq_pkg::WC_SEC_LSB +: 2];

	// swap raises both load and store, so any nonzero code catches it
	// failed store exclusive is dropped; fault path is outside this block
	assign type_ok = (ls[0] & acc_load_in)
		| (ls[1] & acc_store_in & (~acc_excl_in | excl_pass_in));
	// the access's own attribute, code b00 never matches
	assign priv_ok = acc_priv_in ? priv[0] : priv[1];
	// code b11 is reserved and never matches
	assign sec_ok = (sec == wpq_pkg::SEC_BOTH)
		| ((sec == wpq_pkg::SEC_NS) & ~acc_secure_in)
		| ((sec == wpq_pkg::SEC_S) & acc_secure_in);
	assign link_ok = ~ctrl_in[wpq_pkg::WC_LINK_BIT] | ctx_hit_in;

	// all qualifiers for the same access
	assign match_out = ctrl_in[wpq_pkg::WC_EN_BIT] & addr_hit_in
		& type_ok & priv_ok & sec_ok & link_ok;
endmodule

// ### logic/wpq_own.sv
// wpq_own: ownership flags and unlock state of the management window
// assumes write strobes are already decoded and gated by the caller
`timescale 1ns/10ps
module wpq_own #(
	parameter int OWN_W = wpq_pkg::OWN_W,
	parameter logic [31:0] KEY = wpq_pkg::UNLOCK_KEY_DEF
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic set_we_in,
	input wire logic clr_we_in,
	input wire logic key_we_in,
	input wire logic [31:0] wdata_in,
	output logic [OWN_W-1:0] tags_out,
	output logic locked_out
);
	logic [OWN_W-1:0] tags_reg;
	logic [OWN_W-1:0] tags_next;
	logic locked_reg;
	logic locked_next;

	// ==========================================================
	// ones set flags, ones clear flags; set wins if both land at once
	always_comb begin
		tags_next = tags_reg;
		if (clr_we_in) begin
			tags_next = tags_next & ~wdata_in[OWN_W-1:0];
		end
		if (set_we_in) begin
			tags_next = tags_next | wdata_in[OWN_W-1:0];
		end
		// only the exact key opens, anything else closes
		locked_next = locked_reg;
		if (key_we_in) begin
			locked_next = (wdata_in != KEY);
		end
	end

	// registered state
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			tags_reg <= OWN_W'(wpq_pkg::OWN_RESET);
			locked_reg <= wpq_pkg::LOCK_RESET;
		end else if (ce_in) begin
			tags_reg <= tags_next;
			locked_reg <= locked_next;
		end
	end

	assign tags_out = tags_reg;
	assign locked_out = locked_reg;
endmodule

// ### logic/wpq_top.sv
// wpq_top: watchpoint hit qualification and debug management registers
// assumes a coprocessor register port with one-cycle answer and an
// access stream from the load/store path with address compare done upstream
`timescale 1ns/10ps
module wpq_top #(
	parameter int WP_NUM = wpq_pkg::WP_NUM,
	parameter logic [31:0] UNLOCK_KEY = wpq_pkg::UNLOCK_KEY_DEF,
	parameter logic [31:0] COMP_ID = wpq_pkg::COMP_ID_DEF,
	parameter logic [31:0] COMP_CLASS = wpq_pkg::COMP_CLASS_DEF
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// coprocessor register port
	input wire logic cp_req_in,
	input wire logic cp_wr_in,
	input wire logic [11:0] cp_addr_in,
	input wire logic [31:0] cp_wdata_in,
	output logic [31:0] cp_rdata_out,
	output logic cp_ack_out,
	// load/store access stream
	input wire logic acc_valid_in,
	input wire logic acc_load_in,
	input wire logic acc_store_in,
	input wire logic acc_excl_in,
	input wire logic excl_pass_in,
	input wire logic acc_priv_in,
	input wire logic acc_secure_in,
	input wire logic [WP_NUM-1:0] addr_hit_in,
	input wire logic [WP_NUM-1:0] ctx_hit_in,
	// authentication levels
	input wire logic dbgen_in,
	input wire logic niden_in,
	input wire logic spiden_in,
	input wire logic spniden_in,
	// results
	output logic [WP_NUM-1:0] wp_hit_out,
	output logic debug_event_out,
	output logic integ_mode_out
);
	logic [31:0] wc_reg [WP_NUM];
	logic [31:0] wc_next [WP_NUM];
	logic itc_reg;
	logic itc_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] rd_val;
	logic ack_reg;
	logic ack_next;
	logic [WP_NUM-1:0] match;
	logic [WP_NUM-1:0] hit_reg;
	logic [WP_NUM-1:0] hit_next;
	logic ev_reg;
	logic ev_next;
	logic [7:0] perm;
	logic [wpq_pkg::OWN_W-1:0] own_tags;
	logic locked;
	logic wr_any;
	logic wr_ok;

	// ==========================================================
	// decode helpers
	function automatic logic wc_sel(input logic [11:0] a, input int i);
		return a == (wpq_pkg::OFF_WC_BASE + 12'(4 * i));
	endfunction

	function automatic logic [1:0] perm_code(input logic on);
		return on ? wpq_pkg::PERMIT_ON : wpq_pkg::PERMIT_OFF;
	endfunction

	// only the key register stays writable while locked
	assign wr_any = cp_req_in & cp_wr_in;
	assign wr_ok = wr_any & ~locked;

	// ==========================================================
	// watch control and integration control
	always_comb begin
		for (int i = 0; i < WP_NUM; i++) begin
			wc_next[i] = wc_reg[i];
			if (wr_ok && wc_sel(cp_addr_in, i)) begin
				// unwritable bits are dropped so they read as zero
				wc_next[i] = cp_wdata_in & wpq_pkg::WC_WMASK;
			end
		end
		itc_next = itc_reg;
		if (wr_ok && cp_addr_in == wpq_pkg::OFF_ITC) begin
			itc_next = cp_wdata_in[wpq_pkg::ITC_BIT];
		end
	end

	// every watchpoint comes out of reset disarmed
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < WP_NUM; i++) begin
				wc_reg[i] <= wpq_pkg::WC_RESET;
			end
			itc_reg <= wpq_pkg::ITC_RESET;
		end else if (ce_in) begin
			for (int i = 0; i < WP_NUM; i++) begin
				wc_reg[i] <= wc_next[i];
			end
			itc_reg <= itc_next;
		end
	end

	// ==========================================================
	// ownership flags and lock
	wpq_own #(
		.OWN_W(wpq_pkg::OWN_W),
		.KEY(UNLOCK_KEY)
	) u_own (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.set_we_in(wr_ok && cp_addr_in == wpq_pkg::OFF_OWN_SET),
		.clr_we_in(wr_ok && cp_addr_in == wpq_pkg::OFF_OWN_CLR),
		.key_we_in(wr_any && cp_addr_in == wpq_pkg::OFF_UNLOCK_KEY),
		.wdata_in(cp_wdata_in),
		.tags_out(own_tags),
		.locked_out(locked)
	);

	// ==========================================================
	// per-watchpoint qualifiers
	for (genvar g = 0; g < WP_NUM; g++) begin : g_qual
		wpq_qual u_qual (
			.ctrl_in(wc_reg[g]),
			.acc_load_in(acc_load_in),
			.acc_store_in(acc_store_in),
			.acc_excl_in(acc_excl_in),
			.excl_pass_in(excl_pass_in),
			.acc_priv_in(acc_priv_in),
			.acc_secure_in(acc_secure_in),
			.addr_hit_in(addr_hit_in[g]),
			.ctx_hit_in(ctx_hit_in[g]),
			.match_out(match[g])
		);
	end

	// hits registered one cycle after the access is offered
	always_comb begin
		hit_next = acc_valid_in ? match : '0;
		ev_next = |hit_next;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			hit_reg <= '0;
			ev_reg <= 1'b0;
		end else if (ce_in) begin
			hit_reg <= hit_next;
			ev_reg <= ev_next;
		end
	end

	// ==========================================================
	// authentication view: ns inv, ns non-inv, s inv, s non-inv
	assign perm = {
		perm_code((dbgen_in | niden_in) & (spiden_in | spniden_in)),
		perm_code(dbgen_in & spiden_in),
		perm_code(dbgen_in | niden_in),
		perm_code(dbgen_in)
	};

	// ==========================================================
	// read mux; anything not listed, key register included, reads zero
	always_comb begin
		rd_val = 32'h0000_0000;
		case (cp_addr_in)
			wpq_pkg::OFF_ITC: begin
				rd_val[wpq_pkg::ITC_BIT] = itc_reg;
			end
			wpq_pkg::OFF_OWN_SET: begin
				rd_val[wpq_pkg::OWN_W-1:0] = '1;
			end
			wpq_pkg::OFF_OWN_CLR: begin
				rd_val[wpq_pkg::OWN_W-1:0] = own_tags;
			end
			wpq_pkg::OFF_UNLOCK_STATE: begin
				rd_val[wpq_pkg::LOCK_IMPL_BIT] = 1'b1;
				rd_val[wpq_pkg::LOCK_SET_BIT] = locked;
			end
			wpq_pkg::OFF_PERMIT: begin
				rd_val[7:0] = perm;
			end
			wpq_pkg::OFF_COMP_ID: begin
				rd_val = COMP_ID;
			end
			wpq_pkg::OFF_COMP_CLASS: begin
				rd_val = COMP_CLASS;
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
		for (int i = 0; i < WP_NUM; i++) begin
			if (wc_sel(cp_addr_in, i)) begin
				rd_val = wc_reg[i];
			end
		end
	end

	// answer one cycle later; read data holds until the next read
	always_comb begin
		ack_next = cp_req_in;
		rdata_next = (cp_req_in && !cp_wr_in) ? rd_val : rdata_reg;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else if (ce_in) begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign cp_rdata_out = rdata_reg;
	assign cp_ack_out = ack_reg;
	assign wp_hit_out = hit_reg;
	assign debug_event_out = ev_reg;
	assign integ_mode_out = itc_reg;

	// ==========================================================
	// checks on watchpoint 0, the debug event line and the register port
	logic [31:0] c0;
	logic [1:0] ls0;
	logic [1:0] pr0;
	logic [1:0] sc0;
	logic acc0;
	assign c0 = wc_reg[0];
	assign ls0 = c0[wpq_pkg::WC_LS_LSB +: 2];
	assign pr0 = c0[wpq_pkg::WC_PRIV_LSB +: 2];
	assign sc0 = c0[wpq_pkg::WC_SEC_LSB +: 2];
	assign acc0 = ce_in & acc_valid_in;

	AST_DISARMED: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && !c0[wpq_pkg::WC_EN_BIT] |=> !wp_hit_out[0])
		else $error("disarmed watchpoint hit");

	AST_RESET_DISARM: assert property (@(posedge ref_clk_in)
		$rose(rst_n_in) && $past(ce_in) |-> !c0[wpq_pkg::WC_EN_BIT])
		else $error("watchpoint armed after reset");

	AST_LOAD_ONLY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && !acc_load_in && ls0 == wpq_pkg::LS_LOAD |=> !wp_hit_out[0])
		else $error("load-only watchpoint hit a non-load");

	AST_SWAP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && acc_load_in && acc_store_in && !acc_excl_in && addr_hit_in[0]
		&& c0[wpq_pkg::WC_EN_BIT] && ls0 != 2'b00 && pr0 == wpq_pkg::PRIV_ANY
		&& sc0 == wpq_pkg::SEC_BOTH && !c0[wpq_pkg::WC_LINK_BIT]
		|=> wp_hit_out[0] ##0 debug_event_out)
		else $error("swap missed an armed watchpoint");

	AST_LDEX: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && acc_load_in && !acc_store_in && acc_excl_in
		&& ls0 == wpq_pkg::LS_STORE |=> !wp_hit_out[0])
		else $error("load exclusive hit a store-only watchpoint");

	AST_STEX: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && !acc_load_in && acc_excl_in && !excl_pass_in |=> !wp_hit_out[0])
		else $error("failed store exclusive hit");

	AST_PRIV: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && !acc_priv_in && pr0 == wpq_pkg::PRIV_ONLY |=> !wp_hit_out[0])
		else $error("user access hit a privileged watchpoint");

	AST_SEC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && acc_secure_in && sc0 == wpq_pkg::SEC_NS |=> !wp_hit_out[0])
		else $error("secure access hit a non-secure watchpoint");

	AST_LINK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && c0[wpq_pkg::WC_LINK_BIT] && !ctx_hit_in[0] |=> !wp_hit_out[0])
		else $error("linked watchpoint hit without context");

	AST_NO_ADDR: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && !(acc_valid_in && addr_hit_in[0]) |=> !wp_hit_out[0])
		else $error("hit without a matching address");

	AST_RAZ: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && cp_req_in && !cp_wr_in && cp_addr_in >= wpq_pkg::OFF_RSV_LO
		&& cp_addr_in <= wpq_pkg::OFF_RSV_HI |=> cp_ack_out && cp_rdata_out == 0)
		else $error("reserved range read nonzero");

	AST_ACK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in |=> cp_ack_out == $past(cp_req_in))
		else $error("register answer not one cycle after request");

	AST_ITC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && cp_req_in && cp_wr_in && !locked && cp_addr_in == wpq_pkg::OFF_ITC
		|=> integ_mode_out == $past(cp_wdata_in[0]))
		else $error("integration control write lost");

	// a locked window must drop ordinary writes, or a debugger could steal it
	AST_LOCK_GATE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && locked && cp_req_in && cp_wr_in && cp_addr_in == wpq_pkg::OFF_ITC
		|=> $stable(integ_mode_out))
		else $error("write landed while locked");

	AST_USER_ONLY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && acc_priv_in && pr0 == wpq_pkg::PRIV_USER |=> !wp_hit_out[0])
		else $error("privileged access hit a user watchpoint");

	AST_LOAD_HIT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && acc_load_in && !acc_store_in && !acc_excl_in && addr_hit_in[0]
		&& c0[wpq_pkg::WC_EN_BIT] && ls0[0] && pr0 == wpq_pkg::PRIV_ANY
		&& sc0 == wpq_pkg::SEC_BOTH && !c0[wpq_pkg::WC_LINK_BIT] |=> wp_hit_out[0])
		else $error("load missed an armed watchpoint");

	AST_STEX_PASS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		acc0 && !acc_load_in && acc_store_in && acc_excl_in && excl_pass_in && addr_hit_in[0]
		&& c0[wpq_pkg::WC_EN_BIT] && ls0[1] && pr0 == wpq_pkg::PRIV_ANY
		&& sc0 == wpq_pkg::SEC_BOTH && !c0[wpq_pkg::WC_LINK_BIT] |=> wp_hit_out[0])
		else $error("passed store exclusive missed an armed watchpoint");

	// the event line is only ever the union of the per-watchpoint pulses
	AST_EVENT_OR: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		debug_event_out == (wp_hit_out != '0))
		else $error("debug event disagrees with watchpoint hits");
endmodule

// ### verif/wpq_lsu_model.sv
// wpq_lsu_model: load/store path stand-in that feeds the access stream
// assumes one command cycle from the bench becomes one access a cycle later
`timescale 1ns/10ps
module wpq_lsu_model (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic cmd_in,
	input wire logic [2:0] kind_in,
	input wire logic priv_in,
	input wire logic secure_in,
	input wire logic [3:0] hit_in,
	input wire logic [3:0] ctx_in,
	output logic acc_valid_out,
	output logic acc_load_out,
	output logic acc_store_out,
	output logic acc_excl_out,
	output logic excl_pass_out,
	output logic acc_priv_out,
	output logic acc_secure_out,
	output logic [3:0] addr_hit_out,
	output logic [3:0] ctx_hit_out
);
	// ==========================================================
	// access launch
	// kinds: 0 load, 1 store, 2 swap, 3 load excl, 4 store excl ok, 5 store excl failed
	// idle qualifiers flip each cycle so the block cannot lean on stale values
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			{acc_valid_out, acc_load_out, acc_store_out, acc_excl_out} <= 4'h0;
			{excl_pass_out, acc_priv_out, acc_secure_out} <= 3'h0;
			addr_hit_out <= 4'h0;
			ctx_hit_out <= 4'h0;
		end else if (!cmd_in) begin
			acc_valid_out <= 1'h0;
			{acc_load_out, acc_store_out} <= ~{acc_load_out, acc_store_out};
			acc_excl_out <= ~acc_excl_out;
			{excl_pass_out, acc_priv_out} <= ~{excl_pass_out, acc_priv_out};
			acc_secure_out <= ~acc_secure_out;
			addr_hit_out <= ~addr_hit_out;
			ctx_hit_out <= ~ctx_hit_out;
		end else begin
			acc_valid_out <= 1'h1;
			acc_load_out <= kind_in == 3'h0 || kind_in == 3'h2 || kind_in == 3'h3;
			acc_store_out <= kind_in == 3'h1 || kind_in == 3'h2 || kind_in > 3'h3;
			acc_excl_out <= kind_in > 3'h2;
			excl_pass_out <= kind_in == 3'h4;
			acc_priv_out <= priv_in;
			acc_secure_out <= secure_in;
			addr_hit_out <= hit_in;
			ctx_hit_out <= ctx_in;
		end
	end
endmodule

// ### verif/wpq_top_test.sv
// wpq_top_test: register and qualifier checks for the watchpoint block
// assumes default parameters and a one-cycle register answer
`timescale 1ns/10ps
module wpq_top_test;
	logic ref_clk_in = 1'h0;
	logic rst_n_in, ce_in, cp_req_in, cp_wr_in, cmd, prv, sec;
	logic [11:0] cp_addr_in;
	logic [31:0] cp_wdata_in;
	logic dbgen_in, niden_in, spiden_in, spniden_in;
	logic [2:0] kind;
	logic [3:0] hit, ctx, wp_hit_out;
	logic [31:0] cp_rdata_out;
	logic cp_ack_out, debug_event_out, integ_mode_out;
	logic av, al, as, ax, ap, apr, asc;
	logic [3:0] ah, ch;
	logic exp_bit;
	int num_errors = 0;
	int checked = 0;

	always #5 ref_clk_in = ~ref_clk_in;

	wpq_top wpq_top_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
		.cp_req_in(cp_req_in), .cp_wr_in(cp_wr_in), .cp_addr_in(cp_addr_in),
		.cp_wdata_in(cp_wdata_in), .cp_rdata_out(cp_rdata_out), .cp_ack_out(cp_ack_out),
		.acc_valid_in(av), .acc_load_in(al), .acc_store_in(as), .acc_excl_in(ax),
		.excl_pass_in(ap), .acc_priv_in(apr), .acc_secure_in(asc), .addr_hit_in(ah),
		.ctx_hit_in(ch), .dbgen_in(dbgen_in), .niden_in(niden_in), .spiden_in(spiden_in),
		.spniden_in(spniden_in), .wp_hit_out(wp_hit_out), .debug_event_out(debug_event_out),
		.integ_mode_out(integ_mode_out));

	wpq_lsu_model wpq_lsu_model_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd),
		.kind_in(kind), .priv_in(prv), .secure_in(sec), .hit_in(hit), .ctx_in(ctx),
		.acc_valid_out(av), .acc_load_out(al), .acc_store_out(as), .acc_excl_out(ax),
		.excl_pass_out(ap), .acc_priv_out(apr), .acc_secure_out(asc), .addr_hit_out(ah),
		.ctx_hit_out(ch));

	// ==========================================================
	// reporting
	task test_done;
		if (num_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// ==========================================================
	// register port: one request, answer exactly one cycle later
	task cp_access(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		cp_req_in <= 1'h1;
		cp_wr_in <= wr;
		cp_addr_in <= a;
		cp_wdata_in <= d;
		@(posedge ref_clk_in);
		cp_req_in <= 1'h0;
		#1;
		chk({31'h0, cp_ack_out}, 32'h1, "ack");
	endtask

	task cp_rd(input logic [11:0] a, input logic [31:0] exp);
		cp_access(1'h0, a, 32'h0);
		chk(cp_rdata_out, exp, "read data");
	endtask

	// ==========================================================
	// access stream: hit shows two edges after the command, for one cycle
	task acc(input logic [2:0] k, input logic p, input logic s, input logic [3:0] h,
		input logic [3:0] c, input logic [3:0] e);
		@(posedge ref_clk_in);
		{cmd, kind, prv, sec, hit, ctx} <= {1'h1, k, p, s, h, c};
		@(posedge ref_clk_in);
		cmd <= 1'h0;
		@(posedge ref_clk_in);
		#1;
		chk({27'h0, debug_event_out, wp_hit_out}, {27'h0, |e, e}, "hit");
		@(posedge ref_clk_in);
		#1;
		chk({27'h0, debug_event_out, wp_hit_out}, 32'h0, "hit pulse end");
	endtask

	// expected hit from the field encodings, failed store exclusive excluded
	function automatic logic exp_hit(input int k, input int ls, input int pv, input int sc,
		input int p, input int s);
		logic t, pm, sm;
		t = (k == 0 || k == 3) ? ls[0] : (k == 1 || k == 4) ? ls[1] : (ls != 0);
		pm = pv == 3 || (pv == 1 && p == 1) || (pv == 2 && p == 0);
		sm = sc == 0 || (sc == 1 && s == 0) || (sc == 2 && s == 1);
		return t && pm && sm;
	endfunction

	// ==========================================================
	// watchdog: a hang ends the run as a failure
	initial begin
		#1_000_000;
		num_errors++;
		test_done;
	end

	// ==========================================================
	// main sequence
	initial begin
		{rst_n_in, cp_req_in, cp_wr_in, cmd, prv, sec} = 6'h0;
		{dbgen_in, niden_in, spiden_in, spniden_in} = 4'h0;
		ce_in = 1'h1;
		cp_addr_in = 12'h0;
		cp_wdata_in = 32'h0;
		kind = 3'h0;
		hit = 4'h0;
		ctx = 4'h0;
		repeat (5) @(posedge ref_clk_in);
		rst_n_in <= 1'h1;
		for (int i = 0; i < 4; i++) cp_rd(wpq_pkg::OFF_WC_BASE + 12'(4 * i), 32'h0);
		cp_rd(wpq_pkg::OFF_ITC, 32'h0);
		cp_rd(wpq_pkg::OFF_OWN_SET, 32'h0000_00FF);
		cp_rd(wpq_pkg::OFF_OWN_CLR, 32'h0);
		cp_rd(wpq_pkg::OFF_UNLOCK_STATE, 32'h1);
		cp_rd(wpq_pkg::OFF_COMP_ID, wpq_pkg::COMP_ID_DEF);
		cp_rd(wpq_pkg::OFF_COMP_CLASS, wpq_pkg::COMP_CLASS_DEF);
		cp_rd(wpq_pkg::OFF_UNLOCK_KEY, 32'h0);
		// reserved places ignore writes and read zero
		for (int i = 0; i < 3; i++) begin
			cp_access(1'h1, wpq_pkg::OFF_RSV_LO + 12'(i) * 12'h04C, 32'hFFFF_FFFF);
			cp_rd(wpq_pkg::OFF_RSV_LO + 12'(i) * 12'h04C, 32'h0);
		end
		cp_access(1'h1, wpq_pkg::OFF_WC_BASE + 12'h4, 32'hFFFF_FFFF);
		cp_rd(wpq_pkg::OFF_WC_BASE + 12'h4, wpq_pkg::WC_WMASK);
		cp_access(1'h1, wpq_pkg::OFF_WC_BASE + 12'h4, 32'h0);
		// ownership flags: set and clear by ones
		cp_access(1'h1, wpq_pkg::OFF_OWN_SET, 32'h0000_0005);
		cp_access(1'h1, wpq_pkg::OFF_OWN_CLR, 32'h0000_0004);
		cp_rd(wpq_pkg::OFF_OWN_CLR, 32'h1);
		// lock blocks other writes until the key comes back
		cp_access(1'h1, wpq_pkg::OFF_UNLOCK_KEY, 32'h0);
		cp_rd(wpq_pkg::OFF_UNLOCK_STATE, 32'h3);
		cp_access(1'h1, wpq_pkg::OFF_ITC, 32'h1);
		cp_rd(wpq_pkg::OFF_ITC, 32'h0);
		cp_access(1'h1, wpq_pkg::OFF_UNLOCK_KEY, wpq_pkg::UNLOCK_KEY_DEF);
		cp_access(1'h1, wpq_pkg::OFF_ITC, 32'h1);
		chk({31'h0, integ_mode_out}, 32'h1, "integration mode");
		cp_access(1'h1, wpq_pkg::OFF_ITC, 32'h0);
		// a frozen enable drops the request: no answer and no write
		@(posedge ref_clk_in);
		ce_in <= 1'h0;
		cp_req_in <= 1'h1;
		cp_wr_in <= 1'h1;
		cp_addr_in <= wpq_pkg::OFF_ITC;
		cp_wdata_in <= 32'h0000_0001;
		@(posedge ref_clk_in);
		ce_in <= 1'h1;
		cp_req_in <= 1'h0;
		#1;
		chk({31'h0, cp_ack_out}, 32'h0, "frozen ack");
		chk({31'h0, integ_mode_out}, 32'h0, "frozen write");
		// every combination of the authentication levels
		for (int v = 0; v < 16; v++) begin
			@(posedge ref_clk_in);
			{dbgen_in, niden_in, spiden_in, spniden_in} <= 4'(v);
			cp_rd(wpq_pkg::OFF_PERMIT, {24'h0, 1'h1, v[3:2] != 0 && v[1:0] != 0, 1'h1,
				v[3] && v[1], 1'h1, v[3:2] != 0, 1'h1, v[3]});
		end
		// qualifier sweep; cfg packs access, privilege and security codes
		for (int cfg = 0; cfg < 64; cfg++) begin
			cp_access(1'h1, wpq_pkg::OFF_WC_BASE, {16'h0, cfg[1:0], 9'h0, cfg[5:4], cfg[3:2], 1'h1});
			// a packs kind, privilege and security of the access
			for (int a = 0; a < 20; a++) begin
				exp_bit = exp_hit(a / 4, cfg[5:4], cfg[3:2], cfg[1:0], a[1], a[0]);
				acc(3'(a / 4), a[1], a[0], 4'h3, 4'h0, {3'h0, exp_bit});
			end
		end
		cp_access(1'h1, wpq_pkg::OFF_WC_BASE, 32'h0000_001E);
		acc(3'h0, 1'h1, 1'h0, 4'h1, 4'h0, 4'h0);
		cp_access(1'h1, wpq_pkg::OFF_WC_BASE, 32'h0010_001F);
		acc(3'h0, 1'h1, 1'h0, 4'h1, 4'h0, 4'h0);
		acc(3'h0, 1'h1, 1'h0, 4'h1, 4'h1, 4'h1);
		cp_access(1'h1, wpq_pkg::OFF_WC_BASE, 32'h0000_001F);
		cp_access(1'h1, wpq_pkg::OFF_WC_BASE + 12'hC, 32'h0000_001F);
		acc(3'h0, 1'h1, 1'h0, 4'h0, 4'h0, 4'h0);
		acc(3'h2, 1'h0, 1'h1, 4'hF, 4'h0, 4'h9);
		acc(3'h5, 1'h1, 1'h0, 4'h1, 4'h0, 4'h0);
		test_done;
	end
endmodule
